// ### rtl/dxirq_latch.sv
// top of the dual external interrupt latch: registers and two channels
`timescale 1ns/1ps
`default_nettype none
module dxirq_latch
    import dxirq_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ext_line_one_pin,   // active-low pin, line one
    input wire logic ext_line_two_pin,   // active-low pin, shared_port_pin
    input wire logic [7:0] addr,         // register address
    input wire logic [7:0] wdata,        // write data
    input wire logic wr,                 // write strobe
    input wire logic rd,                 // read strobe
    output logic [7:0] rdata,            // read data, cycle after rd
    input wire logic [1:0] vector_fetch, // vector fetch per line, one cycle
    input wire logic break_state,        // cpu in debug break
    input wire logic break_clear_enable, // from break_flag_control_reg
    output logic [1:0] irq_request,      // to interrupt priority logic
    output logic branch_pin_level,       // line one level for branch_if_pin_high/low
    output logic line_two_pullup_disable // 1: pull-up on line two off
);

    // ============================================================
    // control registers
    dxirq_ctrl_t ctrl [2]; // index 0 line one, 1 line two
    logic [1:0] soft_ack;
    logic [1:0] pending;
    logic [1:0] level;
    logic wr_one;
    logic wr_two;
    logic ack_ok;

    assign wr_one = wr && (addr == DXIRQ_LINE_ONE_ADDR);
    assign wr_two = wr && (addr == DXIRQ_LINE_TWO_ADDR);
    // software acknowledges in break only count when enabled; vector fetch is not gated
    assign ack_ok = !break_state || break_clear_enable;

    // mask and sensitivity bits, cleared by reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl[0] <= '{sens: DXIRQ_SENS_RST, block: DXIRQ_BLOCK_RST};
            ctrl[1] <= '{sens: DXIRQ_SENS_RST, block: DXIRQ_BLOCK_RST};
        end else begin
            if (wr_one) begin
                ctrl[0].sens <= wdata[DXIRQ_SENS_BIT];
                ctrl[0].block <= wdata[DXIRQ_BLOCK_BIT];
            end
            if (wr_two) begin
                ctrl[1].sens <= wdata[DXIRQ_SENS_BIT];
                ctrl[1].block <= wdata[DXIRQ_BLOCK_BIT];
            end
        end
    end

    // pull-up disable on line two only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            line_two_pullup_disable <= DXIRQ_PULLUP_RST;
        end else if (wr_two) begin
            line_two_pullup_disable <= wdata[DXIRQ_PULLUP_BIT];
        end
    end

    // acknowledge bits are never stored, they act as pulses
    assign soft_ack[0] = wr_one && wdata[DXIRQ_ACK_BIT] && ack_ok;
    assign soft_ack[1] = wr_two && wdata[DXIRQ_ACK_BIT] && ack_ok;

    // ============================================================
    // the two channels
    for (genvar i = 0; i < 2; i++) begin : g_ch
        dxirq_channel u_ch (
            .clk(clk),
            .reset_n(reset_n),
            .pin_n(i == 0 ? ext_line_one_pin : ext_line_two_pin),
            .ctrl(ctrl[i]),
            .vector_ack(vector_fetch[i]),
            .soft_ack(soft_ack[i]),
            .pin_level(level[i]),
            .pending(pending[i]),
            .request(irq_request[i])
        );
    end

    // only line one reaches the branch condition
    assign branch_pin_level = level[0];

    // ============================================================
    // read port: flag, mask, sensitivity; ack reads zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= DXIRQ_RDATA_RST;
        end else if (rd && addr == DXIRQ_LINE_ONE_ADDR) begin
            rdata <= 8'h00;
            rdata[DXIRQ_FLAG_BIT] <= pending[0];
            rdata[DXIRQ_BLOCK_BIT] <= ctrl[0].block;
            rdata[DXIRQ_SENS_BIT] <= ctrl[0].sens;
        end else if (rd && addr == DXIRQ_LINE_TWO_ADDR) begin
            rdata <= 8'h00;
            rdata[DXIRQ_PULLUP_BIT] <= line_two_pullup_disable;
            rdata[DXIRQ_FLAG_BIT] <= pending[1];
            rdata[DXIRQ_BLOCK_BIT] <= ctrl[1].block;
            rdata[DXIRQ_SENS_BIT] <= ctrl[1].sens;
        end else begin
            rdata <= 8'h00; // unmapped or idle reads zero
        end
    end

    // ============================================================
    // checks
    break_guard_a: assert property (@(posedge clk) disable iff (!reset_n)
        (break_state && !break_clear_enable) |-> soft_ack == 2'b00)
        else $error("ack honoured in break without enable");

    ack_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        rd |=> rdata[DXIRQ_ACK_BIT] == 1'b0)
        else $error("ack bit read non-zero");

    flag_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd && addr == DXIRQ_LINE_ONE_ADDR) |=> rdata[DXIRQ_FLAG_BIT] == $past(pending[0]))
        else $error("line one flag wrong");

    flag_nomask_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd && addr == DXIRQ_LINE_TWO_ADDR) |=> rdata[DXIRQ_FLAG_BIT] == $past(pending[1]))
        else $error("line two flag wrong");

    // read data stands one cycle only, zero otherwise
    rd_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        !rd |=> rdata == 8'h00)
        else $error("read data stood without a read");

endmodule // dxirq_latch
`default_nettype wire

// ### common/dxirq_pkg.sv
// package: register map, field layout and reset values of the dual external interrupt latch
// ============================================================
// How it works
// - two independent maskable external interrupt channels
// - only a falling pin edge sets the request latch
// - vector fetch clears only its own latch
// - software acknowledge write clears channel latch
// - any reset clears every latch
// - edge mode: acknowledge clears latch at once
// - level mode: needs acknowledge and pin high
// - level mode: low pin keeps request pending
// - reset clears sensitivity select with latch
// - mask blocks forwarding, latch is kept
// - later falling edge relatches after acknowledge
// - pending flag ignores the mask bit
// - only line one level feeds branch condition
// - break clear enable lets acknowledges clear
// - break clear disabled: software acknowledges ignored in break, vector fetch still clears
// - registers at 0x1e and 0x1c
// - line one pending flag read-only
// - line one acknowledge write-only, reads zero
// - line one mask read/write, resets zero
// - line one sensitivity read/write, resets zero
// - line two pull-up disable, resets zero
// - line two has same flag/ack/mask/sensitivity
package dxirq_pkg;

    // ============================================================
    // register map
    localparam logic [7:0] DXIRQ_LINE_TWO_ADDR = 8'h1c; // line_two_status_control
    localparam logic [7:0] DXIRQ_LINE_ONE_ADDR = 8'h1e; // line_one_status_control

    // ============================================================
    // field positions inside a status and control register
    localparam int DXIRQ_SENS_BIT = 0;   // sensitivity select
    localparam int DXIRQ_BLOCK_BIT = 1;  // request block (mask)
    localparam int DXIRQ_ACK_BIT = 2;    // clear strobe, write-only
    localparam int DXIRQ_FLAG_BIT = 3;   // pending flag, read-only
    localparam int DXIRQ_PULLUP_BIT = 4; // line two pull-up disable

    // ============================================================
    // reset values
    localparam logic DXIRQ_SENS_RST = 1'b0;
    localparam logic DXIRQ_BLOCK_RST = 1'b0;
    localparam logic DXIRQ_PULLUP_RST = 1'b0;
    localparam logic [7:0] DXIRQ_RDATA_RST = 8'h00;
    localparam logic DXIRQ_PIN_IDLE = 1'b1;  // sync and history start high, so no false edge
    localparam logic DXIRQ_LATCH_RST = 1'b0; // request latch empty after reset

    // per-channel control bits carried together
    typedef struct packed {
        logic sens;  // 1: falling edge and low level
        logic block; // 1: request not forwarded
    } dxirq_ctrl_t;

endpackage : dxirq_pkg

// ### rtl/dxirq_channel.sv
// one external interrupt channel: synchroniser, edge detect and request latch
`timescale 1ns/1ps
`default_nettype none
module dxirq_channel
    import dxirq_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pin_n,         // raw active-low pin
    input var dxirq_ctrl_t ctrl,    // sensitivity and mask
    input wire logic vector_ack,    // vector fetch acknowledge, one cycle
    input wire logic soft_ack,      // software acknowledge, one cycle, break-gated
    output logic pin_level,         // synchronised pin level
    output logic pending,           // latched request, or pin low in level mode
    output logic request            // request to priority logic
);

    // ============================================================
    // synchroniser and edge detect
    logic sync_a; // first stage, read only by sync_b
    logic sync_b; // second stage
    logic prev;   // previous sample for edge compare
    logic latch;  // request latch
    logic fall;
    logic ack;

    // two-flop synchroniser then one history flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= DXIRQ_PIN_IDLE;
            sync_b <= DXIRQ_PIN_IDLE;
            prev <= DXIRQ_PIN_IDLE;
        end else begin
            sync_a <= pin_n;
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end

    assign fall = prev & ~sync_b;
    assign ack = vector_ack | soft_ack;

    // ============================================================
    // request latch; a new edge wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latch <= DXIRQ_LATCH_RST;
        end else if (fall) begin
            latch <= 1'b1;
        end else if (ack) begin
            latch <= 1'b0;
        end
    end

    // level mode keeps the request alive while the pin stays low,
    // an acknowledge on a low pin must not drop it even for one cycle
    assign pending = latch | (ctrl.sens & ~sync_b);
    assign request = pending & ~ctrl.block;
    assign pin_level = sync_b;

    // ============================================================
    // checks
    sequence fall_seen;
        $fell(sync_b);
    endsequence

    edge_sets_a: assert property (@(posedge clk) disable iff (!reset_n)
        fall_seen |=> latch)
        else $error("falling edge did not set latch");

    edge_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!ctrl.sens && ack && !fall) |=> !pending)
        else $error("edge mode ack did not clear");

    level_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (ctrl.sens && !sync_b) |-> pending)
        else $error("level mode request dropped while low");

    mask_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl.block |-> !request)
        else $error("masked request forwarded");

endmodule // dxirq_channel
`default_nettype wire

// ### tb/dxirq_source_model.sv
// external interrupt sources pulling the two active-low pins
`timescale 1ns/1ps
`default_nettype none
module dxirq_source_model (
    input wire logic clk,
    input wire logic [1:0] pull_low, // 1: source pulls that line low
    input wire logic pullup_disable, // line two pull-up switched off
    output logic line_one_pin,
    output logic line_two_pin
);
    // ============================================================
    // floating level
    // an unpulled released line must not read as a clean high, so it wanders
    logic float_lvl = 1'b0;
    always_ff @(posedge clk) begin
        float_lvl <= ~float_lvl;
    end
    // line one has a permanent pull-up
    assign line_one_pin = ~pull_low[0];
    // line two is pulled up only while the pull-up is enabled
    assign line_two_pin = pull_low[1] ? 1'b0 : (pullup_disable ? float_lvl : 1'b1);
endmodule // dxirq_source_model
`default_nettype wire

// ### tb/tb_dxirq_latch.sv
// self-checking bench of the dual external interrupt latch
`timescale 1ns/1ps
`default_nettype none
module tb_dxirq_latch
    import dxirq_pkg::*;
;
    // ============================================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] vector_fetch = 2'b00;
    logic break_state = 1'b0;
    logic break_clear_enable = 1'b0;
    logic [1:0] pull_low = 2'b00; // what the sources drive
    logic pin_one, pin_two;
    logic [7:0] rdata;
    logic [1:0] irq_request;
    logic branch_pin_level, line_two_pullup_disable;
    int error_cnt = 0;
    int checks = 0;
    // field masks derived from the package layout
    localparam logic [7:0] sens_b = 8'h01 << DXIRQ_SENS_BIT;
    localparam logic [7:0] mask_b = 8'h01 << DXIRQ_BLOCK_BIT;
    localparam logic [7:0] ack_b = 8'h01 << DXIRQ_ACK_BIT;
    localparam logic [7:0] flag_b = 8'h01 << DXIRQ_FLAG_BIT;
    localparam logic [7:0] pud_b = 8'h01 << DXIRQ_PULLUP_BIT;
    localparam logic [7:0] one_a = DXIRQ_LINE_ONE_ADDR;
    localparam logic [7:0] two_a = DXIRQ_LINE_TWO_ADDR;

    dxirq_latch dxirq_latch_i (.clk(clk), .reset_n(reset_n), .ext_line_one_pin(pin_one),
        .ext_line_two_pin(pin_two), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .vector_fetch(vector_fetch), .break_state(break_state),
        .break_clear_enable(break_clear_enable), .irq_request(irq_request),
        .branch_pin_level(branch_pin_level), .line_two_pullup_disable(line_two_pullup_disable));
    dxirq_source_model dxirq_source_model_i (.clk(clk), .pull_low(pull_low),
        .pullup_disable(line_two_pullup_disable), .line_one_pin(pin_one), .line_two_pin(pin_two));

    // ============================================================
    // clock and shared tasks
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", exp, rdata);
    endtask
    task automatic irq_chk(input logic [1:0] exp);
        #1 chk("irq_request", {6'h00, exp}, {6'h00, irq_request});
    endtask
    // pin change, then the sync and history delay of three edges plus margin
    task automatic pull(input int ch, input logic v);
        @(posedge clk);
        pull_low[ch] <= v;
        repeat (4) @(posedge clk);
    endtask
    task automatic vf(input logic [1:0] v);
        @(posedge clk);
        vector_fetch <= v;
        @(posedge clk);
        vector_fetch <= 2'b00;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // a hang is cut short here
    initial begin
        #400000;
        error_cnt++;
        print_verdict;
    end

    // ============================================================
    // test sequence
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(one_a, 8'h00);
        rd_chk(two_a, 8'h00);
        chk("pullup", 8'h00, {7'h00, line_two_pullup_disable});
        wr_reg(one_a, ack_b | mask_b | sens_b | flag_b);
        rd_chk(one_a, mask_b | sens_b);
        wr_reg(two_a, ack_b | mask_b | sens_b | pud_b);
        rd_chk(two_a, mask_b | sens_b | pud_b);
        chk("pullup", 8'h01, {7'h00, line_two_pullup_disable});
        wr_reg(8'h1d, 8'hff);
        rd_chk(8'h1d, 8'h00);
        wr_reg(one_a, 8'h00);
        wr_reg(two_a, 8'h00);
        // the floating line may have latched meanwhile; settle and clear it
        repeat (4) @(posedge clk);
        wr_reg(two_a, ack_b);
        $display("test registers done");
        for (int ch = 0; ch < 2; ch++) begin
            pull(ch, 1'b1);
            irq_chk(2'b01 << ch);
            chk("branch", {7'h00, ch[0]}, {7'h00, branch_pin_level});
            rd_chk(ch ? two_a : one_a, flag_b);
            vf(2'b10 >> ch);
            irq_chk(2'b01 << ch);
            vf(2'b01 << ch);
            irq_chk(2'b00);
            pull(ch, 1'b0);
        end
        $display("test edge and vector done");
        wr_reg(one_a, mask_b);
        pull(0, 1'b1);
        irq_chk(2'b00);
        rd_chk(one_a, mask_b | flag_b);
        wr_reg(one_a, 8'h00);
        irq_chk(2'b01);
        wr_reg(one_a, ack_b);
        irq_chk(2'b00);
        pull(0, 1'b0);
        pull(0, 1'b1);
        irq_chk(2'b01);
        wr_reg(one_a, ack_b);
        pull(0, 1'b0);
        $display("test mask and relatch done");
        wr_reg(two_a, sens_b);
        pull(1, 1'b1);
        wr_reg(two_a, sens_b | ack_b);
        irq_chk(2'b10);
        pull(1, 1'b0);
        irq_chk(2'b00);
        pull(1, 1'b1);
        pull(1, 1'b0);
        irq_chk(2'b10);
        wr_reg(two_a, sens_b | ack_b);
        irq_chk(2'b00);
        pull(1, 1'b1);
        vf(2'b10);
        irq_chk(2'b10);
        wr_reg(two_a, sens_b | mask_b);
        irq_chk(2'b00);
        rd_chk(two_a, sens_b | mask_b | flag_b);
        pull(1, 1'b0);
        rd_chk(two_a, sens_b | mask_b);
        wr_reg(two_a, 8'h00);
        $display("test level mode done");
        @(posedge clk) break_state <= 1'b1;
        pull(0, 1'b1);
        wr_reg(one_a, ack_b);
        irq_chk(2'b01);
        @(posedge clk) break_clear_enable <= 1'b1;
        wr_reg(one_a, ack_b);
        irq_chk(2'b00);
        @(posedge clk) break_state <= 1'b0;
        repeat (2) @(posedge clk);
        irq_chk(2'b00);
        @(posedge clk) break_clear_enable <= 1'b0;
        pull(0, 1'b0);
        $display("test break done");
        wr_reg(one_a, sens_b);
        pull(0, 1'b1);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        irq_chk(2'b00);
        pull(0, 1'b0);
        reset_n <= 1'b1;
        rd_chk(one_a, 8'h00);
        $display("test reset done");
        print_verdict;
    end
endmodule // tb_dxirq_latch
`default_nettype wire
